// File: testbench/fcs_cell_model.sv
// Behavioural cell array that answers the sequencer's word programming requests.
`timescale 1ns/1ps
module fcs_cell_model (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        arst_n,
    // Programming handshake
    input  wire        cellPgmReq,
    input  wire [31:0] cellPgmAddr,
    input  wire [31:0] cellClrMask,
    output reg         cellPgmAck,
    output reg         cellPgmErr,
    // Behaviour set by the bench
    input  wire [7:0]  ackDelay,
    input  wire [15:0] failAt
);
    reg     [31:0] mem [0:127];
    reg     [7:0]  waitCnt;
    integer        nDone;
    integer        k;

    initial begin
        nDone = 0;
        for (k = 0; k < 128; k = k + 1) mem[k] = 32'hFFFF_FFFF;
    end

    // Each word is answered by a one-cycle pulse after ackDelay idle cycles.
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cellPgmAck <= 1'b0;
            cellPgmErr <= 1'b0;
            waitCnt    <= 8'h00;
        end else if (cellPgmAck || cellPgmErr) begin
            cellPgmAck <= 1'b0;
            cellPgmErr <= 1'b0;
            waitCnt    <= 8'h00;
        end else if (cellPgmReq && waitCnt < ackDelay) begin
            waitCnt <= waitCnt + 8'h01;
        end else if (cellPgmReq && nDone == failAt) begin
            cellPgmErr <= 1'b1;
        end else if (cellPgmReq) begin
            cellPgmAck <= 1'b1;
            mem[cellPgmAddr[8:2]] <= mem[cellPgmAddr[8:2]] & ~cellClrMask;
            nDone <= nDone + 1;
        end
    end
endmodule

// File: testbench/fcs_sequencer_asserts.sv
// Concurrent checks on the ports of the flash command sequencer.
`timescale 1ns/1ps
module fcs_sequencer_asserts #(
    parameter PAGE_WORDS = 128,
    parameter NUM_BLOCKS = 8,
    parameter BLK_LSB    = 15
) (
    // Clock and reset
    input wire                  sys_clk,
    input wire                  arst_n,
    // Bus side
    input wire                  busWrEn,
    input wire                  busWrWord,
    input wire [31:0]           busWrAddr,
    input wire [31:0]           busWrData,
    input wire                  busRdEn,
    input wire                  busRdAllowed,
    input wire                  busRdRefused,
    input wire [NUM_BLOCKS-1:0] blockProtect,
    // Cell array side
    input wire                  cellPgmReq,
    input wire [31:0]           cellPgmAddr,
    input wire [31:0]           cellClrMask,
    input wire                  cellPgmAck,
    input wire                  cellPgmErr,
    // Status
    input wire [31:0]           flashControlStatusReg,
    input wire                  readyBusyFlag,
    input wire                  autoMode
);
    localparam [31:0] OFS_MASK = PAGE_WORDS * 4 - 1;
    localparam [31:0] LAST_OFS = PAGE_WORDS * 4 - 4;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_ready_mirror: assert property (readyBusyFlag == flashControlStatusReg[0])
        else $error("ready flag differs from status bit 0");
    a_busy_in_auto: assert property (autoMode == !readyBusyFlag)
        else $error("ready flag does not track automatic operation");
    a_read_refused: assert property (busRdEn && autoMode |-> busRdRefused && !busRdAllowed)
        else $error("read not refused in automatic operation");
    a_read_allowed: assert property (busRdEn && !autoMode |-> busRdAllowed && !busRdRefused)
        else $error("read refused in read mode");
    a_auto_entry: assert property ($rose(autoMode) |-> $past(busWrEn && busWrWord && busWrData == 32'h0000_00A0))
        else $error("automatic operation entered without a program command");
    a_idle_no_req: assert property (!autoMode |-> !cellPgmReq)
        else $error("cell request outside automatic operation");
    a_req_holds: assert property (cellPgmReq && !cellPgmAck && !cellPgmErr
        |=> cellPgmReq && $stable(cellPgmAddr) && $stable(cellClrMask))
        else $error("cell request changed before its answer");
    a_addr_step: assert property (cellPgmReq && cellPgmAck && !cellPgmErr && (cellPgmAddr & OFS_MASK) != LAST_OFS
        |=> cellPgmReq && cellPgmAddr == $past(cellPgmAddr) + 32'h0000_0004)
        else $error("next cell word not at the following address");
    a_page_done: assert property (cellPgmReq && cellPgmAck && !cellPgmErr && (cellPgmAddr & OFS_MASK) == LAST_OFS
        |=> !cellPgmReq && readyBusyFlag && !autoMode)
        else $error("page end did not return to read mode");
    a_fail_locks: assert property (cellPgmReq && cellPgmErr
        |=> !cellPgmReq && flashControlStatusReg[1] && !readyBusyFlag)
        else $error("cell failure did not lock the device");
    a_lock_stays: assert property (flashControlStatusReg[1] |=> flashControlStatusReg[1] && autoMode)
        else $error("lock left without hardware reset");
    a_read_cmd: assert property (busWrEn && busWrWord && busWrData == 32'h0000_00F0 && !autoMode
        |=> !autoMode && readyBusyFlag)
        else $error("read command did not keep read mode");
endmodule

bind fcs_sequencer fcs_sequencer_asserts #(
    .PAGE_WORDS(PAGE_WORDS), .NUM_BLOCKS(NUM_BLOCKS), .BLK_LSB(BLK_LSB)
) fcs_sequencer_asserts_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .busWrEn(busWrEn), .busWrWord(busWrWord),
    .busWrAddr(busWrAddr), .busWrData(busWrData), .busRdEn(busRdEn), .busRdAllowed(busRdAllowed),
    .busRdRefused(busRdRefused), .blockProtect(blockProtect), .cellPgmReq(cellPgmReq),
    .cellPgmAddr(cellPgmAddr), .cellClrMask(cellClrMask), .cellPgmAck(cellPgmAck), .cellPgmErr(cellPgmErr),
    .flashControlStatusReg(flashControlStatusReg), .readyBusyFlag(readyBusyFlag), .autoMode(autoMode)
);

// File: testbench/fcs_sequencer_test.sv
// Self-checking bench for the flash command sequencer with a 64-word page.
`timescale 1ns/1ps
`include "fcs_flash_seq_regs.vh"
module fcs_sequencer_test;
    localparam PW = 64;
    reg         sys_clk = 1'b0;
    reg         arst_n = 1'b0;
    reg         busWrEn = 1'b0;
    reg         busWrWord = 1'b0;
    reg  [31:0] busWrAddr = 32'h0000_0000;
    reg  [31:0] busWrData = 32'h0000_0000;
    reg         busRdEn = 1'b0;
    reg  [7:0]  blockProtect = 8'h00;
    reg  [7:0]  ackDelay = 8'h00;
    reg  [15:0] failAt = 16'hFFFF;
    wire        busRdAllowed, busRdRefused, cellPgmReq, cellPgmAck, cellPgmErr, readyBusyFlag, autoMode;
    wire [31:0] cellPgmAddr, cellClrMask, flashControlStatusReg;
    integer     n_fail = 0;
    integer     n_compared = 0;

    always #2.5 sys_clk = ~sys_clk;

    fcs_sequencer #(.PAGE_WORDS(PW), .NUM_BLOCKS(8), .BLK_LSB(15)) fcs_sequencer_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .busWrEn(busWrEn), .busWrWord(busWrWord),
        .busWrAddr(busWrAddr), .busWrData(busWrData), .busRdEn(busRdEn), .busRdAllowed(busRdAllowed),
        .busRdRefused(busRdRefused), .blockProtect(blockProtect), .cellPgmReq(cellPgmReq),
        .cellPgmAddr(cellPgmAddr), .cellClrMask(cellClrMask), .cellPgmAck(cellPgmAck), .cellPgmErr(cellPgmErr),
        .flashControlStatusReg(flashControlStatusReg), .readyBusyFlag(readyBusyFlag), .autoMode(autoMode));
    fcs_cell_model fcs_cell_model_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .cellPgmReq(cellPgmReq), .cellPgmAddr(cellPgmAddr),
        .cellClrMask(cellClrMask), .cellPgmAck(cellPgmAck), .cellPgmErr(cellPgmErr),
        .ackDelay(ackDelay), .failAt(failAt));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task results;
        begin
            $display("COUNTS compared=%0d failed=%0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // One bus write cycle, sampled at the edge it returns on.
    task wr(input [31:0] a, input [31:0] d, input w);
        begin
            busWrEn <= 1'b1; busWrWord <= w; busWrAddr <= a; busWrData <= d; busRdEn <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task cmd3(input [31:0] d);
        begin
            wr(`FCS_CYC1_ADDR, `FCS_CYC1_DATA, 1'b1);
            wr(`FCS_CYC2_ADDR, `FCS_CYC2_DATA, 1'b1);
            wr(`FCS_CYC3_ADDR, d, 1'b1);
        end
    endtask
    // Reads and checks status; m[0] is the mode, m[1] the cell request.
    task seeMode(input [31:0] st, input [1:0] m);
        begin
            busWrEn <= 1'b0; busRdEn <= 1'b1;
            @(posedge sys_clk); #1;
            chk(flashControlStatusReg, st);
            chk({31'b0, autoMode}, {31'b0, m[0]});
            chk({31'b0, busRdAllowed}, {31'b0, ~m[0]});
            chk({31'b0, busRdRefused}, {31'b0, m[0]});
            chk({31'b0, cellPgmReq}, {31'b0, m[1]});
            @(posedge sys_clk);
        end
    endtask
    function [31:0] dat(input integer i);
        dat = (i == 0) ? `FCS_CYC1_DATA : (i == 5) ? `FCS_READ_CMD_DATA : (32'h5A00_0000 | i);
    endfunction
    task load(input [31:0] base);
        integer i;
        begin
            for (i = 0; i < PW; i = i + 1) wr(base + i * 4, dat(i), 1'b1);
        end
    endtask
    task waitEnd;
        integer i;
        begin
            busWrEn <= 1'b0;
            for (i = 0; i < 2000 && readyBusyFlag !== 1'b1 && flashControlStatusReg[1] !== 1'b1; i = i + 1)
                @(posedge sys_clk);
            if (i == 2000) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t wait=%h limit=%h", $time, i, 2000);
                results;
            end
        end
    endtask
    task hwReset;
        begin
            busWrEn <= 1'b0; arst_n <= 1'b0;
            repeat (2) @(posedge sys_clk);
            arst_n <= 1'b1;
            @(posedge sys_clk);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task s_cancel;
        begin
            wr(`FCS_CYC1_ADDR, `FCS_CYC1_DATA, 1'b1);
            cmd3(`FCS_CYC3_RST_DATA);
            seeMode(32'h0000_0001, 2'b00);
            wr(`FCS_CYC1_ADDR, `FCS_CYC1_DATA, 1'b1);
            wr(`FCS_CYC2_ADDR, 32'h0000_0066, 1'b1);
            wr(`FCS_CYC3_ADDR, `FCS_CYC3_PROG_DATA, 1'b1);
            seeMode(32'h0000_0001, 2'b00);
            wr(`FCS_CYC1_ADDR, `FCS_CYC1_DATA, 1'b1);
            wr(`FCS_CYC2_ADDR, `FCS_CYC2_DATA, 1'b0);
            wr(`FCS_CYC3_ADDR, `FCS_CYC3_PROG_DATA, 1'b1);
            seeMode(32'h0000_0001, 2'b00);
            wr(`FCS_CYC1_ADDR, `FCS_CYC1_DATA, 1'b1);
            wr(32'h0001_2344, `FCS_READ_CMD_DATA, 1'b1);
            wr(`FCS_CYC2_ADDR, `FCS_CYC2_DATA, 1'b1);
            wr(`FCS_CYC3_ADDR, `FCS_CYC3_PROG_DATA, 1'b1);
            seeMode(32'h0000_0001, 2'b00);
        end
    endtask
    task s_program;
        integer i, n0;
        begin
            n0 = fcs_cell_model_i.nDone;
            ackDelay <= 8'h03;
            cmd3(`FCS_CYC3_PROG_DATA);
            seeMode(32'h0000_0000, 2'b01);
            load(32'h0000_0100);
            wr(32'h0000_0104, `FCS_READ_CMD_DATA, 1'b1);
            cmd3(`FCS_CYC3_RST_DATA);
            seeMode(32'h0000_0000, 2'b11);
            waitEnd;
            seeMode(32'h0000_0001, 2'b00);
            chk(fcs_cell_model_i.nDone - n0, PW);
            for (i = 0; i < PW; i = i + 1) chk(fcs_cell_model_i.mem[64 + i], dat(i));
        end
    endtask
    task s_protect;
        integer n0;
        begin
            n0 = fcs_cell_model_i.nDone;
            blockProtect <= 8'h02;
            cmd3(`FCS_CYC3_PROG_DATA);
            load(32'h0000_8000);
            waitEnd;
            seeMode(32'h0000_0001, 2'b00);
            chk(fcs_cell_model_i.nDone, n0);
            blockProtect <= 8'h00;
        end
    endtask
    task s_abort;
        begin
            ackDelay <= 8'h08;
            cmd3(`FCS_CYC3_PROG_DATA);
            load(32'h0000_0200);
            repeat (20) @(posedge sys_clk);
            hwReset;
            seeMode(32'h0000_0001, 2'b00);
        end
    endtask
    task s_fail;
        begin
            ackDelay <= 8'h00;
            failAt <= fcs_cell_model_i.nDone + 2;
            cmd3(`FCS_CYC3_PROG_DATA);
            load(32'h0001_0000);
            waitEnd;
            seeMode(32'h0000_0002, 2'b01);
            wr(32'h0001_0000, `FCS_READ_CMD_DATA, 1'b1);
            cmd3(`FCS_CYC3_RST_DATA);
            seeMode(32'h0000_0002, 2'b01);
            failAt <= 16'hFFFF;
            hwReset;
            seeMode(32'h0000_0001, 2'b00);
        end
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        seeMode(32'h0000_0001, 2'b00);
        s_cancel;
        s_program;
        s_protect;
        s_abort;
        s_fail;
        results;
    end
endmodule

// File: verilog/fcs_cmd_match.v
// Pattern table that compares one bus write cycle against the expected command cycles.
`timescale 1ns/1ps
`include "fcs_flash_seq_regs.vh"

module fcs_cmd_match (
    // Current position in the command sequence
    input  wire [1:0]  cmdStep,
    // Bus write cycle under test
    input  wire [31:0] wrAddr,
    input  wire [31:0] wrData,
    // Comparison results
    output reg         firstHit,
    output reg         stepHit,
    output reg         progHit,
    output reg         rstHit
);

    reg [31:0] maskedAddr;

    always @* begin
        maskedAddr = wrAddr & `FCS_CMD_ADDR_MASK;
        firstHit   = (maskedAddr == `FCS_CYC1_ADDR) && (wrData == `FCS_CYC1_DATA);
        progHit    = (maskedAddr == `FCS_CYC3_ADDR) && (wrData == `FCS_CYC3_PROG_DATA);
        rstHit     = (maskedAddr == `FCS_CYC3_ADDR) && (wrData == `FCS_CYC3_RST_DATA);
        case (cmdStep)
            `FCS_STEP_RESET: begin
                stepHit = firstHit;
            end
            `FCS_STEP_ONE: begin
                stepHit = (maskedAddr == `FCS_CYC2_ADDR) && (wrData == `FCS_CYC2_DATA);
            end
            `FCS_STEP_TWO: begin
                stepHit = progHit || rstHit;
            end
            default: begin
                stepHit = 1'b0;
            end
        endcase
    end

endmodule

// File: verilog/fcs_flash_seq_regs.vh
// Constants for the flash command sequencer: command patterns, status fields and reset values.
`ifndef FCS_FLASH_SEQ_REGS_VH
`define FCS_FLASH_SEQ_REGS_VH

// ----------------------------------------------------------------------------
// Command sequence patterns
// ----------------------------------------------------------------------------
// Address bits that take part in the command address comparison.
`define FCS_CMD_ADDR_MASK     32'h0000_FFFF
// First bus write cycle of every three-cycle command.
`define FCS_CYC1_ADDR         32'h0000_5400
`define FCS_CYC1_DATA         32'h0000_00AA
// Second bus write cycle of every three-cycle command.
`define FCS_CYC2_ADDR         32'h0000_AA00
`define FCS_CYC2_DATA         32'h0000_0055
// Third bus write cycle address and the two recognised command codes.
`define FCS_CYC3_ADDR         32'h0000_5400
`define FCS_CYC3_PROG_DATA    32'h0000_00A0
`define FCS_CYC3_RST_DATA     32'h0000_00F0
// Single-cycle Read command, accepted at any flash address.
`define FCS_READ_CMD_DATA     32'h0000_00F0

// ----------------------------------------------------------------------------
// Status word layout and reset values
// ----------------------------------------------------------------------------
`define FCS_STAT_RDY_BIT      0
`define FCS_STAT_LOCK_BIT     1
`define FCS_STAT_RESET        32'h0000_0001
`define FCS_STEP_RESET        2'h0
`define FCS_STEP_ONE          2'h1
`define FCS_STEP_TWO          2'h2

`endif

// File: verilog/fcs_page_buf.v
// Page data store and the engine that hands each stored word to the cell array.
`timescale 1ns/1ps

module fcs_page_buf #(
    parameter PAGE_WORDS = 128,
    parameter IDX_W      = 7
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             arst_n,
    // Word store port
    input  wire             storeEn,
    input  wire [IDX_W-1:0] storeIdx,
    input  wire [31:0]      storeData,
    // Programming run control
    input  wire             runStart,
    input  wire [31:0]      pageBase,
    output reg              runDone,
    output reg              runFail,
    // Cell array programming handshake
    output reg              cellPgmReq_ff,
    output reg  [31:0]      cellPgmAddr_ff,
    output reg  [31:0]      cellClrMask_ff,
    input  wire             cellPgmAck,
    input  wire             cellPgmErr
);

    reg [31:0]      pageMem [0:PAGE_WORDS-1];
    reg [IDX_W-1:0] runIdx_ff;
    reg             lastWord;

    always @(posedge sys_clk) begin
        if (storeEn) begin
            pageMem[storeIdx] <= storeData;
        end
    end

    always @* begin
        lastWord = (runIdx_ff == PAGE_WORDS[IDX_W-1:0] - {{(IDX_W-1){1'b0}}, 1'b1});
        runDone  = cellPgmReq_ff && cellPgmAck && !cellPgmErr && lastWord;
        runFail  = cellPgmReq_ff && cellPgmErr;
    end

    // A word is offered until the array acknowledges or rejects it; a set bit in the mask
    // asks the array to take that cell to zero, so a one in the data never
    // reaches a cell and ones are only restored by an erase.
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cellPgmReq_ff  <= 1'b0;
            cellPgmAddr_ff <= 32'h0000_0000;
            cellClrMask_ff <= 32'h0000_0000;
            runIdx_ff      <= {IDX_W{1'b0}};
        end else if (runStart) begin
            cellPgmReq_ff  <= 1'b1;
            cellPgmAddr_ff <= pageBase;
            cellClrMask_ff <= ~pageMem[0];
            runIdx_ff      <= {IDX_W{1'b0}};
        end else if (cellPgmReq_ff && (cellPgmErr || (cellPgmAck && lastWord))) begin
            cellPgmReq_ff <= 1'b0;
        end else if (cellPgmReq_ff && cellPgmAck) begin
            runIdx_ff      <= runIdx_ff + {{(IDX_W-1){1'b0}}, 1'b1};
            cellPgmAddr_ff <= cellPgmAddr_ff + 32'h0000_0004;
            cellClrMask_ff <= ~pageMem[runIdx_ff + {{(IDX_W-1){1'b0}}, 1'b1}];
        end
    end

endmodule

// File: verilog/fcs_sequencer.v
// Flash command sequencer: mode control, command decoding and page programming flow.
`timescale 1ns/1ps
`include "fcs_flash_seq_regs.vh"

module fcs_sequencer #(
    parameter PAGE_WORDS = 128,
    parameter NUM_BLOCKS = 8,
    parameter BLK_LSB    = 15
) (
    // Clock and reset
    input  wire                  sys_clk,
    input  wire                  arst_n,
    // CPU bus write cycles into the flash area
    input  wire                  busWrEn,
    input  wire                  busWrWord,
    input  wire [31:0]           busWrAddr,
    input  wire [31:0]           busWrData,
    // CPU bus reads and fetches from the flash area
    input  wire                  busRdEn,
    output wire                  busRdAllowed,
    output wire                  busRdRefused,
    // Block protection state
    input  wire [NUM_BLOCKS-1:0] blockProtect,
    // Cell array programming handshake
    output wire                  cellPgmReq,
    output wire [31:0]           cellPgmAddr,
    output wire [31:0]           cellClrMask,
    input  wire                  cellPgmAck,
    input  wire                  cellPgmErr,
    // Status
    output wire [31:0]           flashControlStatusReg,
    output wire                  readyBusyFlag,
    output wire                  autoMode
);

    // ------------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------------
    localparam IDX_W   = $clog2(PAGE_WORDS);
    localparam OFF_W   = IDX_W + 2;
    localparam BLK_W   = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [4:0] ST_READ = 5'b0_0001;
    localparam [4:0] ST_CMD  = 5'b0_0010;
    localparam [4:0] ST_LOAD = 5'b0_0100;
    localparam [4:0] ST_PROG = 5'b0_1000;
    localparam [4:0] ST_LOCK = 5'b1_0000;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [4:0]        state_ff;
    reg  [4:0]        nxt_state;
    reg  [1:0]        cmdStep_ff;
    reg  [1:0]        nxt_cmdStep;
    reg  [IDX_W-1:0]  wordIdx_ff;
    reg  [IDX_W-1:0]  nxt_wordIdx;
    reg  [31:0]       pageBase_ff;
    reg  [31:0]       nxt_pageBase;
    reg  [31:0]       status_ff;
    reg  [31:0]       nxt_status;
    reg               storeEn;
    reg               runStart;
    reg  [31:0]       alignedAddr;
    reg  [BLK_W-1:0]  blockSel;
    reg               blockLocked;
    reg               lastLoadWord;
    wire              firstHit;
    wire              stepHit;
    wire              progHit;
    wire              rstHit;
    wire              runDone;
    wire              runFail;
    wire              inReadMode;
    wire              cmdWrite;

    // ------------------------------------------------------------------------
    // Command pattern table
    // ------------------------------------------------------------------------
    fcs_cmd_match u_match (
        .cmdStep  (cmdStep_ff),
        .wrAddr   (busWrAddr),
        .wrData   (busWrData),
        .firstHit (firstHit),
        .stepHit  (stepHit),
        .progHit  (progHit),
        .rstHit   (rstHit)
    );

    // ------------------------------------------------------------------------
    // Page store and programming engine
    // ------------------------------------------------------------------------
    fcs_page_buf #(
        .PAGE_WORDS (PAGE_WORDS),
        .IDX_W      (IDX_W)
    ) u_page (
        .sys_clk        (sys_clk),
        .arst_n         (arst_n),
        .storeEn        (storeEn),
        .storeIdx       (wordIdx_ff),
        .storeData      (busWrData),
        .runStart       (runStart),
        .pageBase       (pageBase_ff),
        .runDone        (runDone),
        .runFail        (runFail),
        .cellPgmReq_ff  (cellPgmReq),
        .cellPgmAddr_ff (cellPgmAddr),
        .cellClrMask_ff (cellClrMask),
        .cellPgmAck     (cellPgmAck),
        .cellPgmErr     (cellPgmErr)
    );

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    // Reads are served only while no automatic operation owns the array.
    assign inReadMode   = (state_ff == ST_READ) || (state_ff == ST_CMD);
    assign busRdAllowed = busRdEn && inReadMode;
    assign busRdRefused = busRdEn && !inReadMode;
    assign autoMode     = !inReadMode;
    assign cmdWrite     = busWrEn && inReadMode;

    assign flashControlStatusReg = status_ff;
    assign readyBusyFlag         = status_ff[`FCS_STAT_RDY_BIT];

    // ------------------------------------------------------------------------
    // Page address helpers
    // ------------------------------------------------------------------------
    // The base keeps the bits above the page offset, so every later word
    // lands inside the same page whatever address the host writes to.
    always @* begin
        alignedAddr  = {busWrAddr[31:OFF_W], {OFF_W{1'b0}}};
        blockSel     = pageBase_ff[BLK_LSB +: BLK_W];
        blockLocked  = blockProtect[blockSel];
        lastLoadWord = (wordIdx_ff == PAGE_WORDS[IDX_W-1:0] - {{(IDX_W-1){1'b0}}, 1'b1});
    end

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always @* begin
        nxt_state    = state_ff;
        nxt_cmdStep  = cmdStep_ff;
        nxt_wordIdx  = wordIdx_ff;
        nxt_pageBase = pageBase_ff;
        nxt_status   = status_ff;
        storeEn      = 1'b0;
        runStart     = 1'b0;
        case (state_ff)
            ST_READ, ST_CMD: begin
                if (cmdWrite) begin
                    if (!busWrWord) begin
                        // A narrower write can never belong to a sequence.
                        nxt_state   = ST_READ;
                        nxt_cmdStep = `FCS_STEP_RESET;
                    end else if (busWrData == `FCS_READ_CMD_DATA) begin
                        // Read command alone, or Read/reset at its third cycle.
                        nxt_state   = ST_READ;
                        nxt_cmdStep = `FCS_STEP_RESET;
                    end else if (stepHit) begin
                        if (cmdStep_ff == `FCS_STEP_TWO) begin
                            if (progHit) begin
                                nxt_state   = ST_LOAD;
                                nxt_wordIdx = {IDX_W{1'b0}};
                                nxt_status[`FCS_STAT_RDY_BIT] = 1'b0;
                            end else begin
                                nxt_state = ST_READ;
                            end
                            nxt_cmdStep = `FCS_STEP_RESET;
                        end else begin
                            nxt_state   = ST_CMD;
                            nxt_cmdStep = cmdStep_ff + 2'h1;
                        end
                    end else if (firstHit) begin
                        // A fresh sequence start abandons the partial one.
                        nxt_state   = ST_CMD;
                        nxt_cmdStep = `FCS_STEP_ONE;
                    end else begin
                        nxt_state   = ST_READ;
                        nxt_cmdStep = `FCS_STEP_RESET;
                    end
                end
            end
            ST_LOAD: begin
                // Every 32-bit write is page data now; command codes included.
                if (busWrEn && busWrWord) begin
                    storeEn     = 1'b1;
                    nxt_wordIdx = wordIdx_ff + {{(IDX_W-1){1'b0}}, 1'b1};
                    if (wordIdx_ff == {IDX_W{1'b0}}) begin
                        nxt_pageBase = alignedAddr;
                    end
                    if (lastLoadWord) begin
                        nxt_state = ST_PROG;
                    end
                end
            end
            ST_PROG: begin
                if (wordIdx_ff == {IDX_W{1'b0}} && cellPgmReq == 1'b0 && !runDone && !runFail) begin
                    if (blockLocked) begin
                        // Protected block: nothing is programmed.
                        nxt_state = ST_READ;
                        nxt_status[`FCS_STAT_RDY_BIT] = 1'b1;
                    end else begin
                        runStart    = 1'b1;
                        nxt_wordIdx = {{(IDX_W-1){1'b0}}, 1'b1};
                    end
                end else if (runFail) begin
                    nxt_state = ST_LOCK;
                    nxt_status[`FCS_STAT_LOCK_BIT] = 1'b1;
                end else if (runDone) begin
                    nxt_state   = ST_READ;
                    nxt_wordIdx = {IDX_W{1'b0}};
                    nxt_status[`FCS_STAT_RDY_BIT] = 1'b1;
                end
            end
            ST_LOCK: begin
                // Only the asynchronous reset leaves this state.
                nxt_state = ST_LOCK;
            end
            default: begin
                nxt_state   = ST_READ;
                nxt_cmdStep = `FCS_STEP_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    // The CPU reset, pin or watchdog, arrives on arst_n and drops any
    // automatic operation straight back into read mode.
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= ST_READ;
            cmdStep_ff  <= `FCS_STEP_RESET;
            wordIdx_ff  <= {IDX_W{1'b0}};
            pageBase_ff <= 32'h0000_0000;
            status_ff   <= `FCS_STAT_RESET;
        end else begin
            state_ff    <= nxt_state;
            cmdStep_ff  <= nxt_cmdStep;
            wordIdx_ff  <= nxt_wordIdx;
            pageBase_ff <= nxt_pageBase;
            status_ff   <= nxt_status;
        end
    end

endmodule
